// ---- ps_mem_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Program memory model
// ----------------------------------------------------------------
module ps_mem_model
  import ps_pkg::*;
(
  // Fetch port
  input wire logic [PC_W-1:0] addr,
  output logic [IW_W-1:0] rdata
);
  // Each word carries its own address, so a wrong fetch shows up
  assign rdata = {3'h5, addr};
endmodule : ps_mem_model

// ---- ps_pkg.sv ----
package ps_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int PC_W = 13;            // Program counter width
  localparam int IW_W = 16;            // Program memory word width
  localparam int LOWB_W = 8;           // Low program counter byte
  localparam int STACK_DEPTH = 16;     // Return stack levels
  localparam int NUM_IRQ = 6;          // Vectored interrupt sources
  localparam int STARTUP_CYCLES = 1024; // Start-up hold, system clocks
  localparam int PHASES = 4;           // System clocks per cycle

  // ----------------------------------------------------------------
  // Program memory entries
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] VEC_RESET = 13'h0000;
  // Index 0 is the highest priority source
  localparam logic [NUM_IRQ-1:0][PC_W-1:0] VEC_TABLE = {
    13'h0018,  // Real time clock
    13'h0014,  // Time base
    13'h0010,  // Timer/event counter 1 overflow
    13'h000c,  // Timer/event counter 0 overflow
    13'h0008,  // External interrupt 1
    13'h0004   // External interrupt 0
  };
  localparam int IRQ_EXT0 = 0;
  localparam int IRQ_EXT1 = 1;
  localparam int IRQ_TMR0 = 2;
  localparam int IRQ_TMR1 = 3;
  localparam int IRQ_TBASE = 4;
  localparam int IRQ_RTC = 5;

  // ----------------------------------------------------------------
  // Register map (word index = byte address bits 3:2, bit 4 clear)
  // ----------------------------------------------------------------
  localparam int AXI_AW = 5;
  localparam logic [1:0] REG_LOWB = 2'h0;   // Byte address 0x00
  localparam logic [1:0] REG_INTEN = 2'h1;  // Byte address 0x04
  localparam logic [1:0] REG_STATUS = 2'h2; // Byte address 0x08
  localparam logic [1:0] REG_PEND = 2'h3;   // Byte address 0x0c
  localparam int INTEN_MASTER_BIT = 8;
  localparam int STAT_DEPTH_LSB = 16;
  localparam int STAT_FULL_BIT = 24;
  localparam int STAT_START_BIT = 25;
  localparam logic [NUM_IRQ-1:0] INTEN_RESET = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Instruction cycle phases
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PS_PH0 = 4'h1,
    PS_PH1 = 4'h2,
    PS_PH2 = 4'h4,
    PS_PH3 = 4'h8
  } ps_phase_t;

endpackage : ps_pkg

// ---- ps_return_stack.sv ----
`timescale 1ns/1ps

module ps_return_stack
  import ps_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Push and pop requests, never both in one cycle
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  // Stack view
  output logic [WIDTH-1:0] top_data,
  output logic [$clog2(DEPTH):0] depth,
  output logic full
);

  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad_depth
    $error("Return stack depth must be a power of two");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Entries, circular
    logic [PW-1:0] ptr;               // Top entry index
    logic [PW:0] count;               // Levels in use
  } ps_stack_state_t;

  ps_stack_state_t s_reg;
  ps_stack_state_t s_next;

  // Circular storage: a push onto a full stack drops the oldest entry
  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.ptr = s_reg.ptr + 1'b1;
      s_next.mem[s_next.ptr] = push_data;
      if (s_reg.count != (PW+1)'(DEPTH))
      begin
        s_next.count = s_reg.count + 1'b1;
      end
    end
    else if (pop && s_reg.count != '0)
    begin
      // Popping an empty stack is ignored and keeps the pointer
      s_next.ptr = s_reg.ptr - 1'b1;
      s_next.count = s_reg.count - 1'b1;
    end
  end

  // Register update
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the storage flops
  assign top_data = s_reg.mem[s_reg.ptr];
  assign depth = s_reg.count;
  assign full = (s_reg.count == (PW+1)'(DEPTH));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stack_push_top_a: assert property (@(posedge clk) disable iff (!reset_n)
    push |=> top_data == $past(push_data))
    else $error("pushed value is not on top");

endmodule : ps_return_stack

// ---- ps_sequencer.sv ----
`timescale 1ns/1ps

// Behaviour
// - Four system clocks per instruction cycle
// - Fetch overlaps execute; transfers add dummy cycle
// - Program counter is thirteen bits wide
// - Counter increments after each fetch
// - Taken skip discards prefetched word
// - Reset clears counter to zero
// - External interrupt 0 vectors to 004
// - External interrupt 1 vectors to 008
// - Timer 0 overflow vectors to 00c
// - Timer 1 overflow vectors to 010
// - Time base event vectors to 014
// - Real time clock vectors to 018
// - Low byte write jumps within page
// - Jump and call load instruction address
// - Return reloads counter from stack
// - Program memory is 8192 sixteen-bit words
// - Start-up timer holds execution 1024 clocks
// - Sixteen level stack; call/interrupt push, return pops
// - Full stack keeps request pending, unacknowledged

module ps_sequencer
  import ps_pkg::*;
#(
  parameter int STARTUP = STARTUP_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Program memory fetch port
  output logic mem_rd,
  output logic [PC_W-1:0] mem_addr,
  input wire logic [IW_W-1:0] mem_rdata,
  // Execute unit
  output logic [IW_W-1:0] instr_word,
  output logic instr_valid,
  output logic cycle_end,
  input wire logic ctl_jump,
  input wire logic ctl_call,
  input wire logic ctl_ret,
  input wire logic ctl_reti,
  input wire logic ctl_skip,
  input wire logic [PC_W-1:0] ctl_target,
  input wire logic wake_req,
  // Interrupt sources
  input wire logic ext_irq0_pin_n,
  input wire logic ext_irq1_pin_n,
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  input wire logic time_base_evt,
  input wire logic rtc_evt,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int CNT_W = $clog2(STARTUP + 1);
  localparam int DW = $clog2(STACK_DEPTH) + 1;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (STARTUP < 1)
  begin : g_bad_startup
    $error("Start-up hold must be at least one clock");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ps_phase_t phase;             // Phase within instruction cycle
    logic [CNT_W-1:0] start_cnt;  // Start-up clocks still to wait
    logic [PC_W-1:0] pc;          // Address fetched in this cycle
    logic [IW_W-1:0] ir;          // Word under execution
    logic ir_valid;               // Low marks a dummy cycle
    logic lowb_pend;              // Low byte write awaiting a boundary
    logic [LOWB_W-1:0] lowb_data; // Low byte value to load
    logic [NUM_IRQ-1:0] int_en;   // Per-source enables
    logic master_en;              // Global enable
    logic [NUM_IRQ-1:0] pending;  // Latched requests
    logic [1:0] irq_meta;         // Pin synchroniser, first stage
    logic [1:0] irq_sync;         // Pin synchroniser, second stage
    logic [1:0] irq_prev;         // Previous synchronised level
    logic aw_have;
    logic [AXI_AW-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ps_seq_state_t;

  ps_seq_state_t s_reg;
  ps_seq_state_t s_next;

  // Return stack view and control
  logic [PC_W-1:0] stack_top;
  logic [DW-1:0] stack_index;
  logic stack_full;
  logic push;
  logic pop;

  // Boundary decisions, also watched by the checks
  logic running;
  logic at_end;
  logic take_ret;
  logic take_jump;
  logic take_skip;
  logic take_lowb;
  logic take_ack;
  logic [NUM_IRQ-1:0] eff;
  logic [NUM_IRQ-1:0] ack_sel;
  logic [PC_W-1:0] ack_vec;

  // Decode a byte address: bit 2 is hit, bits 1:0 the word index
  function automatic logic [2:0] reg_decode(input logic [AXI_AW-1:0] a);
    reg_decode = {(a[AXI_AW-1] == 1'b0) && (a[1:0] == 2'b00), a[3:2]};
  endfunction : reg_decode

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [2:0] dec;
    logic [NUM_IRQ-1:0] events;
    dec = '0;
    events = '0;
    s_next = s_reg;
    push = 1'b0;
    pop = 1'b0;
    take_ret = 1'b0;
    take_jump = 1'b0;
    take_skip = 1'b0;
    take_lowb = 1'b0;
    take_ack = 1'b0;
    ack_sel = '0;
    ack_vec = VEC_RESET;
    running = (s_reg.start_cnt == '0);
    at_end = running && (s_reg.phase == PS_PH3);

    // Pins are synchronised; a falling edge marks a request
    s_next.irq_meta = {ext_irq1_pin_n, ext_irq0_pin_n};
    s_next.irq_sync = s_reg.irq_meta;
    s_next.irq_prev = s_reg.irq_sync;
    events[IRQ_EXT0] = s_reg.irq_prev[0] && !s_reg.irq_sync[0];
    events[IRQ_EXT1] = s_reg.irq_prev[1] && !s_reg.irq_sync[1];
    events[IRQ_TMR0] = tmr0_ovf;
    events[IRQ_TMR1] = tmr1_ovf;
    events[IRQ_TBASE] = time_base_evt;
    events[IRQ_RTC] = rtc_evt;

    // Fixed priority: scan down so the lowest vector is kept
    eff = s_reg.pending & s_reg.int_en;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (eff[i])
      begin
        ack_sel = '0;
        ack_sel[i] = 1'b1;
        ack_vec = VEC_TABLE[i];
      end
    end

    // Start-up hold: phases and fetches stop while counting
    if (wake_req)
    begin
      s_next.start_cnt = CNT_W'(STARTUP);
      s_next.phase = PS_PH0;
    end
    else if (!running)
    begin
      s_next.start_cnt = s_reg.start_cnt - 1'b1;
    end
    else
    begin
      // Phase ring, one instruction cycle per turn
      unique case (s_reg.phase)
        PS_PH0: s_next.phase = PS_PH1;
        PS_PH1: s_next.phase = PS_PH2;
        PS_PH2: s_next.phase = PS_PH3;
        PS_PH3: s_next.phase = PS_PH0;
      endcase
    end

    // Instruction boundary: decide where the next fetch goes
    if (at_end && !wake_req)
    begin
      s_next.ir = mem_rdata;
      if (s_reg.ir_valid)
      begin
        // A dummy cycle ignores the execute unit entirely
        take_ret = ctl_ret;
        take_jump = !ctl_ret && (ctl_jump || ctl_call);
        take_skip = !ctl_ret && !ctl_jump && !ctl_call && ctl_skip;
        take_lowb = !ctl_ret && !ctl_jump && !ctl_call && !ctl_skip &&
                    s_reg.lowb_pend;
        // A full stack holds the request back until a return
        take_ack = !ctl_ret && !ctl_jump && !ctl_call && !ctl_skip &&
                   !s_reg.lowb_pend && s_reg.master_en && (eff != '0) &&
                   !stack_full;
      end
      s_next.pc = s_reg.pc + 1'b1;
      if (take_ret)
      begin
        s_next.pc = stack_top;
        pop = 1'b1;
        if (ctl_reti)
        begin
          s_next.master_en = 1'b1;
        end
      end
      else if (take_jump)
      begin
        s_next.pc = ctl_target;
        push = ctl_call;
      end
      else if (take_lowb)
      begin
        s_next.pc = {s_reg.pc[PC_W-1:LOWB_W], s_reg.lowb_data};
        s_next.lowb_pend = 1'b0;
      end
      else if (take_ack)
      begin
        // The prefetched word is dropped, so its address returns
        s_next.pc = ack_vec;
        push = 1'b1;
        s_next.master_en = 1'b0;
      end
      // Any change of flow turns the next cycle into a dummy
      s_next.ir_valid = !(take_ret || take_jump || take_skip ||
                          take_lowb || take_ack);
    end

    // Set wins over the clear by acknowledge
    s_next.pending = (s_reg.pending & ~(take_ack ? ack_sel : '0)) |
                     events;

    // Write channel: address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_next.w_have = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready)
    begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_have && s_reg.w_have)
    begin
      dec = reg_decode(s_reg.aw_addr);
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = dec[2] ? RESP_OKAY : RESP_SLVERR;
      if (dec[2] && dec[1:0] == REG_LOWB && s_reg.w_strb[0])
      begin
        // Newest write wins if one is still waiting
        s_next.lowb_pend = 1'b1;
        s_next.lowb_data = s_reg.w_data[LOWB_W-1:0];
      end
      if (dec[2] && dec[1:0] == REG_INTEN)
      begin
        if (s_reg.w_strb[0])
        begin
          s_next.int_en = s_reg.w_data[NUM_IRQ-1:0];
        end
        if (s_reg.w_strb[1])
        begin
          s_next.master_en = s_reg.w_data[INTEN_MASTER_BIT];
        end
      end
    end

    // Read channel: one read outstanding at a time
    if (s_reg.rvalid && s_axi_rready)
    begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      dec = reg_decode(s_axi_araddr);
      s_next.rvalid = 1'b1;
      s_next.rdata = '0;
      s_next.rresp = dec[2] ? RESP_OKAY : RESP_SLVERR;
      if (dec[2])
      begin
        unique case (dec[1:0])
          REG_LOWB: s_next.rdata[LOWB_W-1:0] = s_reg.pc[LOWB_W-1:0];
          REG_INTEN:
          begin
            s_next.rdata[NUM_IRQ-1:0] = s_reg.int_en;
            s_next.rdata[INTEN_MASTER_BIT] = s_reg.master_en;
          end
          REG_STATUS:
          begin
            s_next.rdata[PC_W-1:0] = s_reg.pc;
            s_next.rdata[STAT_DEPTH_LSB +: DW] = stack_index;
            s_next.rdata[STAT_FULL_BIT] = stack_full;
            s_next.rdata[STAT_START_BIT] = !running;
          end
          REG_PEND: s_next.rdata[NUM_IRQ-1:0] = s_reg.pending;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
      s_reg.phase <= PS_PH0;
      s_reg.start_cnt <= CNT_W'(STARTUP);
      s_reg.pc <= VEC_RESET;
      s_reg.int_en <= INTEN_RESET;
      s_reg.irq_meta <= 2'h3;
      s_reg.irq_sync <= 2'h3;
      s_reg.irq_prev <= 2'h3;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  ps_return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .clk(clk),
    .reset_n(reset_n),
    .push(push),
    .pop(pop),
    .push_data(s_reg.pc),
    .top_data(stack_top),
    .depth(stack_index),
    .full(stack_full)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_rd = running && (s_reg.phase == PS_PH0);
  assign mem_addr = s_reg.pc;
  assign instr_word = s_reg.ir;
  assign instr_valid = s_reg.ir_valid && running;
  assign cycle_end = at_end;
  assign s_axi_awready = !s_reg.aw_have && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_have && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  cycle_length_a: assert property ((at_end && !wake_req) |=>
    (!at_end [*3]) ##1 (at_end || !running || $past(wake_req)))
    else $error("instruction cycle is not four clocks");
  pc_increment_a: assert property ((at_end && !wake_req &&
    !take_ret && !take_jump && !take_lowb && !take_ack) |=>
    mem_addr == $past(mem_addr) + 1'b1)
    else $error("counter did not step by one");
  reset_zero_a: assert property ($rose(reset_n) |->
    mem_addr == VEC_RESET && !instr_valid)
    else $error("counter not cleared by reset");
  dummy_cycle_a: assert property ((at_end && !s_next.ir_valid) |=>
    !instr_valid [*4])
    else $error("no dummy cycle after a transfer");
  skip_two_a: assert property ((take_skip && !wake_req) |-> ##5
    (mem_addr == $past(mem_addr, 5) + 2'd2 || !running))
    else $error("skip did not advance by two");
  vector_load_a: assert property ((take_ack && !wake_req) |=>
    mem_addr == $past(ack_vec) && mem_addr[1:0] == 2'b00)
    else $error("interrupt vector not loaded");
  ext0_first_a: assert property ((take_ack && eff[IRQ_EXT0] &&
    !wake_req) |=> mem_addr == VEC_TABLE[IRQ_EXT0])
    else $error("lowest vector not served first");
  full_hold_a: assert property ((stack_full && at_end &&
    eff != '0 && !pop) |-> !take_ack ##1 (s_reg.pending != '0))
    else $error("request acknowledged on full stack");
  low_page_a: assert property ((take_lowb && !wake_req) |=>
    mem_addr[PC_W-1:LOWB_W] == $past(mem_addr[PC_W-1:LOWB_W]) &&
    mem_addr[LOWB_W-1:0] == $past(s_reg.lowb_data))
    else $error("low byte jump left the page");
  jump_load_a: assert property ((take_jump && !wake_req) |=>
    mem_addr == $past(ctl_target))
    else $error("jump target not loaded");
  ret_load_a: assert property ((take_ret && !wake_req) |=>
    mem_addr == $past(stack_top))
    else $error("return address not restored");
  startup_hold_a: assert property (!running |->
    !mem_rd && !instr_valid && !cycle_end)
    else $error("execution during start-up hold");

  call_seen_c: cover property (take_jump && ctl_call);
  irq_seen_c: cover property (take_ack);
  full_block_c: cover property (stack_full && eff != '0 && at_end);
  skip_seen_c: cover property (take_skip);

endmodule : ps_sequencer

// ---- tb_program_sequencer.sv ----
`timescale 1ns/1ps

module tb_program_sequencer
  import ps_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, reset_n, mem_rd, instr_valid, cycle_end, wake_req;
  logic ctl_jump, ctl_call, ctl_ret, ctl_reti, ctl_skip;
  logic [PC_W-1:0] mem_addr, ctl_target, pc, sv;
  logic [IW_W-1:0] mem_rdata, instr_word;
  logic [5:0] src; // Event sources, one bit per vector index
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int n_fail, compares;
  // Vectors expected for the sources fired one at a time
  int ix[4] = '{IRQ_EXT0, IRQ_EXT1, IRQ_TMR1, IRQ_TBASE};
  logic [12:0] vx[4] = '{13'h004, 13'h008, 13'h010, 13'h014};

  // Short start-up hold keeps the run brief
  localparam int HOLD = 4;
  ps_sequencer #(.STARTUP(HOLD)) dut_u (.clk, .reset_n, .mem_rd, .mem_addr,
    .mem_rdata, .instr_word, .instr_valid, .cycle_end, .ctl_jump,
    .ctl_call, .ctl_ret, .ctl_reti, .ctl_skip, .ctl_target,
    .wake_req, .ext_irq0_pin_n(~src[0]), .ext_irq1_pin_n(~src[1]),
    .tmr0_ovf(src[2]), .tmr1_ovf(src[3]), .time_base_evt(src[4]),
    .rtc_evt(src[5]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  ps_mem_model mem_u (.addr(mem_addr), .rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  // One executed cycle: k 0 none, 1 jump, 2 call, 3 ret, 4 reti, 5 skip
  task automatic do_ctl(input int k, input logic [12:0] t);
    logic [12:0] exp;
    forever
    begin
      @(posedge clk);
      #1;
      if (mem_rd && instr_valid)
        break;
    end
    pc = mem_addr;
    check("instr_word", instr_word, {3'h5, pc - 13'h1});
    exp = (k == 0 || k == 5) ? pc + 13'h1 : t;
    // Controls sit on the cycle_end edge, three clocks after phase 0
    repeat (3) @(posedge clk);
    // A return from interrupt raises the return strobe as well
    {ctl_skip, ctl_reti, ctl_ret, ctl_call, ctl_jump} <=
      (k == 0) ? 5'h00 : (k == 4) ? 5'h0c : 5'h01 << (k - 1);
    ctl_target <= t;
    #1;
    check("cycle_end", cycle_end, 1'b1);
    @(posedge clk);
    {ctl_skip, ctl_reti, ctl_ret, ctl_call, ctl_jump} <= 5'h00;
    #1;
    check("next_addr", mem_addr, exp);
    check("valid", instr_valid, k == 0);
    check("fetch", mem_rd, 1'b1);
  endtask : do_ctl

  // Wait for the counter to land in v's 32-word area, keep prior address
  task automatic wait_pc(input logic [12:0] v);
    repeat (300)
    begin
      sv = mem_addr;
      @(posedge clk);
      #1;
      if (mem_addr[12:5] === v[12:5])
        break;
    end
    check("landing", mem_addr, v);
  endtask : wait_pc

  task automatic fire(input logic [5:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= 6'h00;
  endtask : fire

  // Start-up hold: no fetch while counting, then a phase 0 fetch
  task automatic hold_chk;
    repeat (HOLD - 1)
    begin
      @(posedge clk);
      #1;
      check("hold", mem_rd, 1'b0);
    end
    @(posedge clk);
    #1;
    check("start", mem_rd, 1'b1);
  endtask : hold_chk

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  initial
  begin
    reset_n = 1'b0;
    src = 6'h00;
    wake_req = 1'b0;
    ctl_target = 13'h0;
    {ctl_skip, ctl_reti, ctl_ret, ctl_call, ctl_jump} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    hold_chk();
    check("reset_pc", mem_addr, 13'h0);
    axi_rd(5'h04);
    check("inten_reset", rd, 32'h0);
    axi_rd(5'h10);
    check("unmapped", resp, RESP_SLVERR);
    do_ctl(1, 13'h100);
    do_ctl(0, 13'h0);
    do_ctl(5, 13'h0);
    do_ctl(2, 13'h120);
    do_ctl(3, pc);
    axi_wr(5'h04, 32'h13f, 4'h3);
    check("bresp", resp, RESP_OKAY);
    axi_wr(5'h00, 32'h55, 4'h1);
    check("bresp", resp, RESP_OKAY);
    wait_pc(13'h155);
    // Two at once: timer 0 first, real time clock after the return
    fire(6'h24);
    wait_pc(13'h00c);
    do_ctl(4, sv);
    wait_pc(13'h018);
    do_ctl(4, sv);
    for (int i = 0; i < 4; i++)
    begin
      fire(6'h01 << ix[i]);
      wait_pc(vx[i]);
      do_ctl(4, sv);
    end
    // Sixteen nested calls fill the stack; a request must then wait
    for (int i = 0; i < STACK_DEPTH; i++)
    begin
      do_ctl(2, 13'h200);
    end
    axi_rd(5'h08);
    check("full", rd[STAT_FULL_BIT], 1'b1);
    fire(6'h01);
    do_ctl(0, 13'h0);
    axi_rd(5'h0c);
    check("pending", rd, 32'h1);
    do_ctl(3, 13'h201);
    wait_pc(13'h004);
    do_ctl(4, sv);
    // Wake-up restarts the hold from phase 0
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    hold_chk();
    finish_test();
  end
endmodule : tb_program_sequencer
